// >>> dv/spi_master_clock_and_select_timing_tb.sv
/* Testbench for the serial master: words in several formats and delays.
   Assumes the slave model and the bound checker. */
`timescale 1ns/1ps
module spi_master_clock_and_select_timing_tb;
    logic        I_CLOCK = 1'b0, I_SRST = 1'b1, hold = 1'b0, start = 1'b0;
    logic [31:0] gcr = 32'h0, fmt = 32'h0;
    logic [15:0] dly = 16'h0, tx = 16'h0, stx = 16'h0;
    logic [7:0]  rwait = 8'h00;
    wire         sclk, mosi, seln, busy, done, ready_n, miso;
    wire  [15:0] rx, srx;
    int          errors = 0, n_tests = 0;
    always #2.5 I_CLOCK = ~I_CLOCK;
    spi_master_timing DUT (.I_CLOCK(I_CLOCK), .I_SRST(I_SRST), .i_global_control_register(gcr),
        .i_word_format_register(fmt), .i_delay_setting_register(dly), .i_select_hold_enable(hold),
        .i_start(start), .i_tx_word(tx), .i_master_data_in(miso), .i_slave_ready_n(ready_n),
        .o_serial_clock_pin(sclk), .o_master_data_out(mosi), .o_select_n(seln), .o_busy(busy),
        .o_done(done), .o_rx_word(rx));
    spi_slave_model slave (.clk(I_CLOCK), .sclk(sclk), .mosi(mosi), .sel_n(seln), .pol(fmt[17]),
        .wait_cycles(rwait), .tx(stx), .ready_n(ready_n), .miso(miso), .rx(srx));
    task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task results;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : results
    // One word: settings first, so the idle level is settled before start
    task run(input logic [7:0] ps, input logic pol, input logic [7:0] c2t, t2c, input logic h,
             input logic [7:0] w, input logic [15:0] d);
        int i;
        @(posedge I_CLOCK);
        fmt <= {14'h0000, pol, 1'b0, ps, 8'h00}; dly <= {c2t, t2c}; hold <= h; rwait <= w;
        tx <= d; stx <= ~d;
        @(posedge I_CLOCK);
        start <= 1'b1;
        @(posedge I_CLOCK);
        start <= 1'b0;
        for (i = 0; i < 20000 && done !== 1'b1; i++) begin @(posedge I_CLOCK); #1; end
        if (i == 20000) begin errors++; results; end
        check("rx word", rx, ~d);
        check("slave word", srx, d);
        check("select", 16'(seln), 16'h0001);
        $display("word done ps %0d pol %0d", ps, pol);
    endtask : run
    initial begin
        repeat (5) @(posedge I_CLOCK);
        I_SRST <= 1'b0; gcr <= 32'h0000_0001;
        run(8'h00, 1'b0, 8'h00, 8'h00, 1'b0, 8'h00, 16'hA5C3);
        run(8'h01, 1'b1, 8'h03, 8'h02, 1'b1, 8'h00, 16'h8001);
        run(8'h04, 1'b0, 8'h05, 8'h01, 1'b0, 8'h14, 16'h3C5A);
        run(8'hFF, 1'b1, 8'h02, 8'h07, 1'b1, 8'h03, 16'hFFFE);
        run(8'h02, 1'b0, 8'hFF, 8'hFF, 1'b0, 8'h00, 16'h0001);
        // Disabled master must ignore start
        @(posedge I_CLOCK); gcr <= 32'h0; start <= 1'b1;
        repeat (4) @(posedge I_CLOCK); start <= 1'b0; #1;
        check("busy off", 16'(busy), 16'h0000);
        $display("disabled test done");
        gcr <= 32'h0000_0001;
        run(8'h07, 1'b1, 8'h01, 8'h00, 1'b0, 8'h01, 16'h6B2D);
        results;
    end
endmodule : spi_master_clock_and_select_timing_tb
bind spi_master_timing spi_master_timing_sva #(.WORD_BITS(WORD_BITS)) u_sva (.I_CLOCK(I_CLOCK), .I_SRST(I_SRST),
    .i_global_control_register(i_global_control_register), .i_word_format_register(i_word_format_register),
    .i_delay_setting_register(i_delay_setting_register), .i_select_hold_enable(i_select_hold_enable),
    .i_start(i_start), .i_slave_ready_n(i_slave_ready_n), .o_serial_clock_pin(o_serial_clock_pin),
    .o_select_n(o_select_n), .o_busy(o_busy), .o_done(o_done));

// >>> dv/spi_master_timing_sva.sv
/* Timing checker for the serial master, bound to its top ports.
   Assumes settings stay steady while a word is in flight. */
`timescale 1ns/1ps
module spi_master_timing_sva #(
    parameter int WORD_BITS = 16
) (
    // Clock, reset and settings
    input wire logic        I_CLOCK,
    input wire logic        I_SRST,
    input wire logic [31:0] i_global_control_register,
    input wire logic [31:0] i_word_format_register,
    input wire logic [15:0] i_delay_setting_register,
    input wire logic        i_select_hold_enable,
    input wire logic        i_start,
    // Pins and status
    input wire logic        i_slave_ready_n,
    input wire logic        o_serial_clock_pin,
    input wire logic        o_select_n,
    input wire logic        o_busy,
    input wire logic        o_done
);
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (I_SRST);
    logic [15:0] sel_cnt, gap;
    logic [6:0]  edges;
    logic        prev, seen;
    // Half period bounds; odd periods split unevenly
    wire       tog = o_serial_clock_pin ^ prev;
    wire [7:0] ps  = i_word_format_register[15:8];
    wire [8:0] per = (ps == 8'h00) ? 9'h002 : {1'b0, ps} + 9'h001;
    wire [8:0] lo  = per >> 1;
    wire [8:0] hi  = per - lo;
    wire [7:0] c2t = i_delay_setting_register[15:8];
    wire [7:0] t2c = i_delay_setting_register[7:0];
    // Counters restart whenever select is released
    always_ff @(posedge I_CLOCK) begin
        prev <= o_serial_clock_pin;
        if (I_SRST || o_select_n) begin
            sel_cnt <= 16'h0000; gap <= 16'h0000; edges <= 7'h00; seen <= 1'b0;
        end else begin
            sel_cnt <= sel_cnt + 16'h0001;
            gap     <= tog ? 16'h0000 : gap + 16'h0001;
            edges   <= edges + 7'(tog);
            seen    <= seen | !i_slave_ready_n;
        end
    end
    a_start_selects: assert property (!o_busy && !o_done && i_start && i_global_control_register[0]
        |=> ##1 !o_select_n && o_busy) else $error("start not taken");
    a_disabled_idle: assert property (!o_busy && !i_global_control_register[0] |=> !o_busy)
        else $error("busy while master disabled");
    a_idle_polarity: assert property ($fell(o_select_n) |-> o_serial_clock_pin == i_word_format_register[17])
        else $error("clock idle level wrong");
    a_first_edge: assert property (tog && !o_select_n && edges == 7'h00
        |-> sel_cnt >= 16'(c2t) + 16'(i_select_hold_enable) + 16'h0002) else $error("first edge early");
    a_ready_first: assert property (tog && !o_select_n |-> seen) else $error("clock before ready");
    a_half_width: assert property (tog && !o_select_n && edges != 7'h00
        |-> gap + 16'h0001 >= 16'(lo) && gap + 16'h0001 <= 16'(hi)) else $error("half period wrong");
    a_edge_count: assert property ($rose(o_select_n) |-> edges == 7'(2 * WORD_BITS))
        else $error("edge count wrong");
    a_select_hold: assert property ($rose(o_select_n)
        |-> gap + 16'h0001 >= 16'(lo) + 16'(t2c) + 16'h0001 && gap <= 16'(hi) + 16'(t2c) + 16'h0002)
        else $error("select hold wrong");
    a_done_pulse: assert property (o_done |-> o_select_n ##1 !o_done) else $error("done not a pulse");
endmodule : spi_master_timing_sva

// >>> dv/spi_slave_model.sv
/* Behavioural serial slave: ready after a wait, MSB-first shifting.
   Assumes it is clocked by the master's interface clock. */
`timescale 1ns/1ps
module spi_slave_model (
    input  wire logic        clk, sclk, mosi, sel_n, pol,
    input  wire logic [7:0]  wait_cycles,
    input  wire logic [15:0] tx,
    output logic             ready_n, miso,
    output logic [15:0]      rx
);
    logic [15:0] sh = 16'h0000;
    logic [7:0]  cnt = 8'h00;
    logic        last = 1'b0;
    initial begin ready_n = 1'b1; rx = 16'h0000; end
    // Released data line shows the inverse so a stale bit never looks valid
    assign miso = sel_n ? ~sh[15] : sh[15];
    // Ready after the programmed wait while selected
    always @(posedge clk) begin
        if (sel_n) begin
            cnt <= 8'h00; ready_n <= 1'b1;
        end else if (cnt < wait_cycles) begin
            cnt <= cnt + 8'h01;
        end else begin
            ready_n <= 1'b0;
        end
    end
    // Shift on the pin's own edges, as a real slave would
    always @(sel_n, sclk, tx) begin
        if (sel_n) sh = tx;
        else if (sclk != last && sclk != pol) rx = {rx[14:0], mosi};
        else if (sclk != last) sh = {sh[14:0], 1'b0};
        last = sclk;
    end
endmodule : spi_slave_model

// >>> include/spi_clk_if.sv
/*
 * Carrier between the master sequencer and its serial clock generator.
 * Assumes both ends share the single interface clock.
 */
`timescale 1ns/1ps
interface spi_clk_if;
    logic       run;      // Generator toggles while high
    logic [7:0] prescale; // Prescale of the current word
    logic       tick;     // Serial clock half-period boundary
    logic [7:0] half;     // Cycles in the longer half-period
    modport gen (input run, input prescale, output tick, output half);
    modport seq (output run, output prescale, input tick, input half);
endinterface : spi_clk_if

// >>> include/spi_timing_pkg.sv
/*
 * Constants for the serial master: format field positions, delay field
 * layout, reset values and word length.
 * Assumes the interface clock runs at 200 MHz and drives every register.
 */
// How it works
// R1 - Global control bit 0 enables master operation
// R2 - Format bit 16 selects clock phase
// R3 - Format bit 17 selects clock polarity
// R4 - Clock period prescale plus one, zero gives two
// R5 - Prescale comes from format bits 15 to 8
// R6 - Delay register holds both select delays
// R7 - First edge after select delay plus 2/3
// R8 - Select held half period plus delay plus one
// R9 - Ready sampled within delay plus 1 or 2
// R10 - No clock edges until ready sampled low
package spi_timing_pkg;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int MASTER_BIT    = 0;
    localparam int PHASE_BIT     = 16;
    localparam int POLARITY_BIT  = 17;
    localparam int PRESCALE_LSB  = 8;
    localparam int PRESCALE_MSB  = 15;
    localparam int C2T_LSB       = 8;
    localparam int C2T_MSB       = 15;
    localparam int T2C_LSB       = 0;
    localparam int T2C_MSB       = 7;
    // ------------------------------------------------------------
    // Counts and reset values
    // ------------------------------------------------------------
    localparam int WORD_BITS     = 16;
    localparam logic [7:0] C2T_EXTRA      = 8'h02;
    localparam logic [7:0] C2T_EXTRA_HOLD = 8'h03;
    localparam logic [7:0] T2C_EXTRA      = 8'h01;
    localparam logic [7:0] MIN_HALF       = 8'h01;
    localparam logic [15:0] SHIFT_RESET   = 16'h0000;
endpackage : spi_timing_pkg

// >>> src/spi_clk_gen.sv
/*
 * Serial clock half-period generator.
 * Assumes the sequencer holds prescale steady while run is high.
 */
`timescale 1ns/1ps
module spi_clk_gen (
    // Clock and reset
    input  wire logic I_CLOCK,
    input  wire logic I_SRST,
    // Sequencer side
    spi_clk_if.gen    clk_port
);
    // ------------------------------------------------------------
    // Half-period length
    // ------------------------------------------------------------
    // Period is prescale+1 cycles, or 2 for prescale 0; odd periods get the longer half first
    logic [8:0] period;
    logic [7:0] half_lo;
    logic [7:0] half_hi;
    logic       phase;
    logic [7:0] count;
    assign period  = (clk_port.prescale == 8'h00) ? 9'd2 : {1'b0, clk_port.prescale} + 9'd1; // [R4]
    assign half_lo = period[8:1];
    assign half_hi = period[8:1] + {7'h00, period[0]};
    assign clk_port.half = half_hi;
    assign clk_port.tick = clk_port.run && (count == 8'h01);

    // Count down each half-period
    always_ff @(posedge I_CLOCK) begin
        if (I_SRST || !clk_port.run) begin
            count <= half_hi;
            phase <= 1'b0;
        end else if (count == 8'h01) begin
            count <= phase ? half_hi : half_lo; // [R4]
            phase <= ~phase;
        end else begin
            count <= count - 8'h01;
        end
    end
endmodule : spi_clk_gen

// >>> src/spi_master_timing.sv
/*
 * Serial master: select-to-clock and clock-to-select timing, prescaled
 * serial clock, polarity choice and slave-ready handshake, one word per
 * start pulse.
 * Assumes all inputs are synchronous to I_CLOCK and that software holds
 * the format and delay settings steady during a word.
 */
`timescale 1ns/1ps
module spi_master_timing #(
    parameter int WORD_BITS = spi_timing_pkg::WORD_BITS
) (
    // Clock and reset
    input  wire logic                 I_CLOCK,
    input  wire logic                 I_SRST,
    // Settings
    input  wire logic [31:0]          i_global_control_register,
    input  wire logic [31:0]          i_word_format_register,
    input  wire logic [15:0]          i_delay_setting_register,
    input  wire logic                 i_select_hold_enable,
    // Word request
    input  wire logic                 i_start,
    input  wire logic [WORD_BITS-1:0] i_tx_word,
    // Serial pins
    input  wire logic                 i_master_data_in,
    input  wire logic                 i_slave_ready_n,
    output logic                      o_serial_clock_pin,
    output logic                      o_master_data_out,
    output logic                      o_select_n,
    // Status
    output logic                      o_busy,
    output logic                      o_done,
    output logic [WORD_BITS-1:0]      o_rx_word
);
    typedef enum logic [4:0] {
        S_IDLE  = 5'b00001,
        S_SETUP = 5'b00010,
        S_SHIFT = 5'b00100,
        S_HOLD  = 5'b01000,
        S_WAIT  = 5'b10000
    } state_t;

    spi_clk_if clk_port ();

    spi_clk_gen u_gen (
        .I_CLOCK  (I_CLOCK),
        .I_SRST   (I_SRST),
        .clk_port (clk_port)
    );

    // ------------------------------------------------------------
    // Setting decode
    // ------------------------------------------------------------
    wire       master_en = i_global_control_register[spi_timing_pkg::MASTER_BIT]; // [R1]
    wire       phase_sel = i_word_format_register[spi_timing_pkg::PHASE_BIT];     // [R2]
    wire       polarity  = i_word_format_register[spi_timing_pkg::POLARITY_BIT];  // [R3]
    wire [7:0] prescale  =
        i_word_format_register[spi_timing_pkg::PRESCALE_MSB:spi_timing_pkg::PRESCALE_LSB]; // [R5]
    wire [7:0] c2t = i_delay_setting_register[spi_timing_pkg::C2T_MSB:spi_timing_pkg::C2T_LSB]; // [R6]
    wire [7:0] t2c = i_delay_setting_register[spi_timing_pkg::T2C_MSB:spi_timing_pkg::T2C_LSB]; // [R6]
    // Nine-bit sums so a full delay does not wrap
    wire [8:0] setup_len = {1'b0, c2t} + {1'b0, i_select_hold_enable ?
                           spi_timing_pkg::C2T_EXTRA_HOLD : spi_timing_pkg::C2T_EXTRA}; // [R7]
    wire [8:0] ready_len = {1'b0, c2t} + 9'd1; // [R9]

    // ------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------
    state_t               state;
    logic [8:0]           timer;
    logic [5:0]           edges;
    logic                 ready_seen;
    logic                 sclk;
    logic [WORD_BITS-1:0] shift_out;
    logic [WORD_BITS-1:0] shift_in;
    logic                 phase_r;
    logic                 sample_due;

    // Tick toggles the clock; even edge count ones are leading edges
    wire tick      = clk_port.tick;
    wire lead_edge = tick && !edges[0];
    wire last_edge = tick && (edges == 6'(2 * WORD_BITS - 1));
    wire timer_end = (timer == 9'd1);
    // Ready is first sampled at c2t+1 cycles into the setup window
    wire ready_pt  = (state == S_SETUP) && (timer == setup_len - ready_len); // [R9]

    assign clk_port.run      = (state == S_SHIFT);
    assign clk_port.prescale = prescale;

    // State and timer update
    always_ff @(posedge I_CLOCK) begin
        if (I_SRST) begin
            state      <= S_IDLE;
            timer      <= 9'd0;
            ready_seen <= 1'b0;
        end else begin
            case (state)
                S_IDLE: begin
                    if (i_start && master_en) begin // [R1]
                        state      <= S_SETUP;
                        timer      <= setup_len; // [R7]
                        ready_seen <= 1'b0;
                    end
                end
                S_SETUP: begin
                    if (ready_pt && !i_slave_ready_n) begin
                        ready_seen <= 1'b1; // [R9]
                    end
                    if (timer_end) begin
                        // Slave not ready: keep select, re-sample each cycle
                        if (ready_seen || !i_slave_ready_n) begin
                            state <= S_SHIFT; // [R10]
                        end
                    end else begin
                        timer <= timer - 9'd1;
                    end
                end
                S_SHIFT: begin
                    if (last_edge) begin
                        state <= S_HOLD;
                        // Half period, then delay plus one cycle
                        timer <= {1'b0, clk_port.half} + {1'b0, t2c} + {1'b0, spi_timing_pkg::T2C_EXTRA}; // [R8]
                    end
                end
                S_HOLD: begin
                    if (timer_end) begin
                        state <= S_WAIT;
                    end else begin
                        timer <= timer - 9'd1;
                    end
                end
                S_WAIT: begin
                    state <= S_IDLE;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // Edge counter and serial clock level
    always_ff @(posedge I_CLOCK) begin
        if (I_SRST) begin
            edges <= 6'd0;
            sclk  <= 1'b0;
        end else if (state != S_SHIFT) begin
            edges <= 6'd0;
            sclk  <= polarity; // [R3]
        end else if (tick) begin
            edges <= edges + 6'd1;
            sclk  <= ~sclk;
        end
    end

    // Transmit shift; phase 0 shifts on the trailing edge
    always_ff @(posedge I_CLOCK) begin
        if (I_SRST) begin
            shift_out <= spi_timing_pkg::SHIFT_RESET;
            phase_r   <= 1'b0;
        end else if (state == S_IDLE && i_start && master_en) begin
            shift_out <= i_tx_word;
            phase_r   <= phase_sel; // [R2]
        end else if (state == S_SHIFT && tick) begin
            if (!(lead_edge ^ phase_r) && (!phase_r || edges != 6'd0)) begin
                shift_out <= {shift_out[WORD_BITS-2:0], 1'b0};
            end
        end
    end

    // Receive sample one cycle after the tick, when the pin edge is out;
    // sampling at the tick itself would read the slave's bit too early
    always_ff @(posedge I_CLOCK) begin
        if (I_SRST) begin
            sample_due <= 1'b0;
            shift_in   <= spi_timing_pkg::SHIFT_RESET;
        end else begin
            sample_due <= (state == S_SHIFT) && tick && (lead_edge ^ phase_r); // [R2]
            if (sample_due) begin
                shift_in <= {shift_in[WORD_BITS-2:0], i_master_data_in}; // [R2]
            end
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge I_CLOCK) begin
        if (I_SRST) begin
            o_serial_clock_pin <= 1'b0;
            o_master_data_out  <= 1'b0;
            o_select_n         <= 1'b1;
            o_busy             <= 1'b0;
            o_done             <= 1'b0;
            o_rx_word          <= spi_timing_pkg::SHIFT_RESET;
        end else begin
            o_serial_clock_pin <= sclk;
            o_master_data_out  <= shift_out[WORD_BITS-1];
            o_select_n         <= !(state == S_SETUP || state == S_SHIFT || state == S_HOLD); // [R8]
            o_busy             <= (state != S_IDLE);
            o_done             <= (state == S_WAIT);
            if (state == S_WAIT) begin
                o_rx_word <= shift_in;
            end
        end
    end
endmodule : spi_master_timing
